// file: pfcfc_mac_model.sv
// pfcfc_mac_model: far side mac transmit path that sends frames and takes pause requests
// assumes pfcfc_port request signals on mclk
`timescale 1ns/100ps
`default_nettype none
module pfcfc_mac_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic busy_en,
	input wire logic slow,
	input wire logic tx_pause_req,
	output logic tx_busy,
	output logic tx_pause_ack
);
	// ****************************************
	// frames and acks
	// ****************************************
	integer seed = 32'h5a44;
	logic [3:0] wait_ff;
	logic [3:0] len_ff;
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wait_ff <= 4'h0;
			len_ff <= 4'h0;
			tx_pause_ack <= 1'b0;
		end
		else
		begin
			wait_ff <= tx_pause_req ? wait_ff + 4'h1 : 4'h0;
			// pause frame goes out only between data frames
			tx_pause_ack <= tx_pause_req && !tx_pause_ack && !tx_busy && (!slow || wait_ff > 4'h4);
			len_ff <= (len_ff != 4'h0) ? len_ff - 4'h1 : (busy_en && $random(seed) % 3 == 0) ? 4'($random(seed) & 7) : 4'h0;
		end
	end
	assign tx_busy = len_ff != 4'h0;
endmodule // pfcfc_mac_model
`default_nettype wire

// file: pfcfc_pkg.sv
// pfcfc_pkg: constants, types and structs for the port pause / priority flow control block
// assumes a single 40 MHz mac clock and a mac that frames and parses pause control frames
package pfcfc_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int PFCFC_NPRI = 8;
	localparam int PFCFC_QW = 16;
	localparam int PFCFC_QUANTA_BITS = 512;
	localparam int PFCFC_LINK_MBPS = 1000;
	localparam int PFCFC_CLK_MHZ = 40;
	// mac clock cycles per pause quantum at the link rate, at least one
	localparam int PFCFC_QUANTUM_NS = (PFCFC_QUANTA_BITS * 1000) / PFCFC_LINK_MBPS;
	localparam int PFCFC_QUANTUM_CYC_RAW = (PFCFC_QUANTUM_NS * PFCFC_CLK_MHZ + 999) / 1000;
	localparam int PFCFC_QUANTUM_CYC = (PFCFC_QUANTUM_CYC_RAW < 1) ? 1 : PFCFC_QUANTUM_CYC_RAW;
	localparam logic [7:0] PFCFC_QUANTUM_CYC_W = 8'(PFCFC_QUANTUM_CYC);

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [PFCFC_QW-1:0] PFCFC_ZERO_Q = 16'h0000;
	localparam logic [PFCFC_NPRI-1:0] PFCFC_NONE = 8'h00;
	localparam logic [PFCFC_NPRI-1:0] PFCFC_ALL = 8'hff;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {PFCFC_MODE_BASE, PFCFC_MODE_PFC} pfcfc_mode_t;

	typedef struct packed {
		logic rx;
		logic tx;
	} pfcfc_adv_t;

	typedef struct packed {
		logic valid;
		logic is_pfc;
		logic [PFCFC_NPRI-1:0] mask;
		logic [PFCFC_NPRI-1:0][PFCFC_QW-1:0] quanta;
	} pfcfc_rxpause_t;

	typedef struct packed {
		logic is_pfc;
		logic [PFCFC_NPRI-1:0] mask;
		logic [PFCFC_QW-1:0] quanta;
	} pfcfc_txpause_t;

endpackage

// file: pfcfc_port.sv
// pfcfc_port: pause and priority flow control for one ethernet port
// assumes the mac frames pause requests and parses received control frames,
// and that every input is synchronous to mclk
//
// Operation
// - base pause quantity is 16 bits, counted in 512 bit time units
// - on pause, finish current frame then send nothing for the duration
// - all flow control settings are per port; one instance per port
// - tx and rx pause enables separate; negotiation never disabled
// - emit pause when receive depth rises past high-water mark
// - each frame received while above low-water triggers another pause
// - below low-water, stop pausing until high-water crossed again
// - accepted pause halts all output queues for the encoded time
// - at 1G link up, settings apply at once; relink renegotiates latest
// - local rx off tx on, partner both on: local transmit only
// - local both on, partner rx off tx on: local receive only
// - both advertise rx on: symmetric pause both directions
// - partner advertises both off: pause disabled both ways
// - pfc frame carries eight 16-bit quanta and a valid bitmask
// - pfc quantum n acts like base pause but stops priority n only
// - pfc keeps eight threshold pairs, depth tracked per priority
// - pfc tx and rx enables set separately per priority
// - one programmed pause time used for every pfc priority
// - both ends must use the same scheme, base or pfc
`timescale 1ns/100ps
`default_nettype none
module pfcfc_port
(
	input wire logic mclk,
	input wire logic rst,
	input wire pfcfc_pkg::pfcfc_mode_t mode,
	input wire pfcfc_pkg::pfcfc_adv_t cfg_adv,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0] pfc_tx_en,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0] pfc_rx_en,
	input wire logic [pfcfc_pkg::PFCFC_QW-1:0] pause_time,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0][pfcfc_pkg::PFCFC_QW-1:0] hi_mark,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0][pfcfc_pkg::PFCFC_QW-1:0] lo_mark,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0][pfcfc_pkg::PFCFC_QW-1:0] rxq_depth,
	input wire logic rx_frame,
	input wire logic [2:0] rx_frame_pri,
	input wire logic link_up,
	input wire logic an_done,
	input wire pfcfc_pkg::pfcfc_adv_t partner_adv,
	input wire pfcfc_pkg::pfcfc_rxpause_t rx_pause,
	input wire logic tx_busy,
	input wire logic tx_pause_ack,
	output pfcfc_pkg::pfcfc_adv_t adv_out,
	output logic eff_tx_en,
	output logic eff_rx_en,
	output logic tx_pause_req,
	output pfcfc_pkg::pfcfc_txpause_t tx_pause,
	output logic [pfcfc_pkg::PFCFC_NPRI-1:0] txq_halt
);
	import pfcfc_pkg::*;

	// ****************************************
	// quantum tick divider
	// ****************************************
	logic [7:0] qdiv_ff;
	logic qtick;

	assign qtick = (qdiv_ff == 8'h00);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			qdiv_ff <= 8'h00;
		else
			qdiv_ff <= qtick ? PFCFC_QUANTUM_CYC_W - 8'h01 : qdiv_ff - 8'h01;
	end

	// ****************************************
	// pause negotiation
	// ****************************************
	function automatic logic [1:0] pfcfc_resolve(input pfcfc_adv_t loc, input pfcfc_adv_t rem);
		logic [1:0] r;
		r = 2'b00; // {tx, rx}, also covers partner both off
		if (loc.rx && rem.rx)
			r = 2'b11;
		else if (!loc.rx && loc.tx && rem.rx && rem.tx)
			r = 2'b10;
		else if (loc.rx && loc.tx && !rem.rx && rem.tx)
			r = 2'b01;
		return r;
	endfunction

	logic neg_valid_ff;
	logic [1:0] neg_ff;
	logic [1:0] neg_res;
	pfcfc_adv_t neg_cfg_ff;
	logic neg_live;

	assign neg_res = pfcfc_resolve(cfg_adv, partner_adv);
	// latest configuration is always advertised; negotiation has no off switch
	assign adv_out = cfg_adv;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			neg_valid_ff <= 1'b0;
			neg_ff <= 2'b00;
			neg_cfg_ff <= '0;
		end
		else if (!link_up)
			neg_valid_ff <= 1'b0;
		else if (an_done)
		begin
			neg_valid_ff <= 1'b1;
			neg_ff <= neg_res;
			neg_cfg_ff <= cfg_adv;
		end
	end

	// negotiated result holds while the settings match what was advertised;
	// settings changed while up apply immediately
	logic tx_allowed;
	logic rx_allowed;
	assign neg_live = neg_valid_ff && (cfg_adv == neg_cfg_ff);
	assign tx_allowed = neg_live ? neg_ff[1] : cfg_adv.tx;
	assign rx_allowed = neg_live ? neg_ff[0] : cfg_adv.rx;

	logic is_pfc;
	assign is_pfc = (mode == PFCFC_MODE_PFC);

	// every setting is a port of this instance, so ports never share flow control state
	logic [PFCFC_NPRI-1:0] gen_en;
	logic [PFCFC_NPRI-1:0] hon_en;
	assign gen_en = is_pfc ? (tx_allowed ? pfc_tx_en : PFCFC_NONE) : (tx_allowed ? 8'h01 : PFCFC_NONE);
	assign hon_en = is_pfc ? (rx_allowed ? pfc_rx_en : PFCFC_NONE) : (rx_allowed ? PFCFC_ALL : PFCFC_NONE);

	// ****************************************
	// pause generation from receive depth
	// ****************************************
	logic [PFCFC_NPRI-1:0] cong_ff;
	logic [PFCFC_NPRI-1:0] nxt_cong;
	logic [PFCFC_NPRI-1:0] trig;
	logic [PFCFC_NPRI-1:0] pend_ff;
	logic [PFCFC_NPRI-1:0] nxt_pend;
	logic [PFCFC_NPRI-1:0] rise;

	genvar g;
	generate
		for (g = 0; g < PFCFC_NPRI; g++)
		begin : gen_mark
			// base mode watches only the port total carried in lane 0
			logic over_hi;
			logic under_lo;
			logic frame_hit;
			assign over_hi = rxq_depth[g] > hi_mark[g];
			assign under_lo = rxq_depth[g] < lo_mark[g];
			assign frame_hit = rx_frame && (!is_pfc || rx_frame_pri == 3'(g));
			assign nxt_cong[g] = under_lo ? 1'b0 : (over_hi ? 1'b1 : cong_ff[g]);
			assign rise[g] = over_hi && !cong_ff[g];
			// a frame received while still above low-water repeats the pause
			assign trig[g] = gen_en[g] && (rise[g] || (cong_ff[g] && !under_lo && frame_hit));
		end
	endgenerate

	// base frames carry no mask, so their acknowledge retires lane 0
	logic [PFCFC_NPRI-1:0] sent_mask;
	assign sent_mask = tx_pause.is_pfc ? tx_pause.mask : 8'h01;
	// set wins over the acknowledge clear
	assign nxt_pend = (pend_ff & ~(tx_pause_ack ? sent_mask : PFCFC_NONE)) | trig;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cong_ff <= PFCFC_NONE;
			pend_ff <= PFCFC_NONE;
		end
		else
		begin
			cong_ff <= nxt_cong;
			pend_ff <= nxt_pend;
		end
	end

	// outgoing request holds until the mac acknowledges
	logic req_ff;
	pfcfc_txpause_t txp_ff;

	assign tx_pause_req = req_ff;
	assign tx_pause = txp_ff;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			req_ff <= 1'b0;
			txp_ff <= '0;
		end
		else if (!req_ff || tx_pause_ack)
		begin
			req_ff <= (nxt_pend != PFCFC_NONE);
			txp_ff.is_pfc <= is_pfc;
			txp_ff.mask <= is_pfc ? nxt_pend : PFCFC_NONE;
			txp_ff.quanta <= pause_time; // single time for all priorities
		end
	end

	// ****************************************
	// received pause handling
	// ****************************************
	logic [PFCFC_NPRI-1:0] tmr_load;
	logic [PFCFC_NPRI-1:0] tmr_active;
	logic [PFCFC_NPRI-1:0][PFCFC_QW-1:0] tmr_val;
	logic rx_ok;

	assign rx_ok = rx_pause.valid && (rx_pause.is_pfc == is_pfc);

	generate
		for (g = 0; g < PFCFC_NPRI; g++)
		begin : gen_tmr
			// base pause loads every priority; pfc only masked lanes
			assign tmr_load[g] = rx_ok && hon_en[g] && (is_pfc ? rx_pause.mask[g] : 1'b1);
			assign tmr_val[g] = is_pfc ? rx_pause.quanta[g] : rx_pause.quanta[0];
			pfcfc_timer u_tmr
			(
				.mclk(mclk),
				.rst(rst),
				.qtick(qtick),
				.load(tmr_load[g]),
				.value(tmr_val[g]),
				.active(tmr_active[g])
			);
		end
	endgenerate

	// halt rises and lowers only between frames so a frame in flight completes
	logic [PFCFC_NPRI-1:0] halt_ff;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			halt_ff <= PFCFC_NONE;
		else if (!tx_busy)
			halt_ff <= tmr_active & hon_en;
	end

	assign txq_halt = halt_ff;
	assign eff_tx_en = tx_allowed;
	assign eff_rx_en = rx_allowed;

endmodule // pfcfc_port
`default_nettype wire

// file: pfcfc_properties.sv
// pfcfc_properties: port level checks of pfcfc_port
// assumes a bind to every pfcfc_port instance, one mclk domain
`timescale 1ns/100ps
`default_nettype none
module pfcfc_properties
(
	input wire logic mclk,
	input wire logic rst,
	input wire pfcfc_pkg::pfcfc_mode_t mode,
	input wire pfcfc_pkg::pfcfc_adv_t cfg_adv,
	input wire pfcfc_pkg::pfcfc_rxpause_t rx_pause,
	input wire logic tx_busy,
	input wire logic tx_pause_ack,
	input wire pfcfc_pkg::pfcfc_adv_t adv_out,
	input wire logic eff_rx_en,
	input wire logic tx_pause_req,
	input wire pfcfc_pkg::pfcfc_txpause_t tx_pause,
	input wire logic [pfcfc_pkg::PFCFC_NPRI-1:0] txq_halt
);
	import pfcfc_pkg::*;
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic is_pfc_mode = mode == PFCFC_MODE_PFC;
	wire logic base_acc = rx_pause.valid && !rx_pause.is_pfc && !is_pfc_mode && eff_rx_en;
	property p_adv; adv_out == cfg_adv; endproperty
	a_adv: assert property (p_adv) else $error("adv_out differs from cfg_adv");
	property p_req_hold; tx_pause_req && !tx_pause_ack |=> tx_pause_req; endproperty
	a_req_hold: assert property (p_req_hold) else $error("pause request dropped before ack");
	property p_req_data; tx_pause_req && !tx_pause_ack |=> $stable(tx_pause); endproperty
	a_req_data: assert property (p_req_data) else $error("pause payload changed while pending");
	property p_req_mode; tx_pause_req |-> tx_pause.is_pfc == is_pfc_mode; endproperty
	a_req_mode: assert property (p_req_mode) else $error("generated frame kind differs from mode");
	property p_halt; base_acc && rx_pause.quanta[0] != 16'h0000 ##1 !tx_busy |=> txq_halt == PFCFC_ALL;
	endproperty
	a_halt: assert property (p_halt) else $error("base pause did not halt all queues");
	property p_halt_idle; (txq_halt & ~$past(txq_halt)) != PFCFC_NONE |-> !$past(tx_busy); endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("halt raised during a frame");
	property p_zero; base_acc && rx_pause.quanta[0] == 16'h0000 ##1 !tx_busy [*3] |-> txq_halt == PFCFC_NONE;
	endproperty
	a_zero: assert property (p_zero) else $error("zero pause did not end halt");
	property p_refuse; !tx_busy && !rx_pause.valid ##1 rx_pause.valid && rx_pause.is_pfc != is_pfc_mode
		&& txq_halt == PFCFC_NONE && !tx_busy |=> txq_halt == PFCFC_NONE [*2]; endproperty
	a_refuse: assert property (p_refuse) else $error("foreign scheme pause halted queues");
	c_ack: cover property (tx_pause_req && tx_pause_ack);
	c_all: cover property (txq_halt == PFCFC_ALL);
	c_part: cover property (txq_halt != PFCFC_NONE && txq_halt != PFCFC_ALL);
endmodule // pfcfc_properties
bind pfcfc_port pfcfc_properties i_pfcfc_properties (.mclk(mclk), .rst(rst), .mode(mode), .cfg_adv(cfg_adv),
	.rx_pause(rx_pause), .tx_busy(tx_busy), .tx_pause_ack(tx_pause_ack), .adv_out(adv_out), .eff_rx_en(eff_rx_en),
	.tx_pause_req(tx_pause_req), .tx_pause(tx_pause), .txq_halt(txq_halt));
`default_nettype wire

// file: pfcfc_timer.sv
// pfcfc_timer: one pause countdown in pause quanta
// assumes qtick pulses once per 512 bit times
`timescale 1ns/100ps
`default_nettype none
module pfcfc_timer
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic qtick,
	input wire logic load,
	input wire logic [pfcfc_pkg::PFCFC_QW-1:0] value,
	output logic active
);
	import pfcfc_pkg::*;

	logic [PFCFC_QW-1:0] count_ff;
	logic [PFCFC_QW-1:0] nxt_count;

	// a new frame reloads, zero ends the pause
	assign nxt_count = load ? value : ((qtick && count_ff != PFCFC_ZERO_Q) ? count_ff - 16'h0001 : count_ff);
	assign active = (count_ff != PFCFC_ZERO_Q);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			count_ff <= PFCFC_ZERO_Q;
		else
			count_ff <= nxt_count;
	end
endmodule // pfcfc_timer
`default_nettype wire

// file: tb.sv
// tb: self checking bench of pfcfc_port with a mac model on its transmit side
// assumes the checker is bound by its own file
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pfcfc_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, rx_frame = 1'b0, link_up = 1'b0, an_done = 1'b0, busy_en = 1'b0, slow = 1'b0;
	logic tx_busy, tx_pause_ack, eff_tx_en, eff_rx_en, tx_pause_req, got;
	pfcfc_mode_t mode = PFCFC_MODE_BASE;
	pfcfc_adv_t cfg_adv = 2'h3, partner_adv = 2'h0, adv_out;
	logic [7:0] pfc_tx_en = 8'hff, pfc_rx_en = 8'hff, txq_halt, m;
	logic [15:0] pause_time = 16'h0123;
	logic [7:0][15:0] hi_mark = {8{16'h0064}}, lo_mark = {8{16'h0032}}, rxq_depth = {8{16'h0000}};
	logic [2:0] rx_frame_pri = 3'h0;
	pfcfc_rxpause_t rx_pause = '0;
	pfcfc_txpause_t tx_pause, tp;
	pfcfc_adv_t lt [4] = '{2'h1, 2'h3, 2'h2, 2'h3};
	pfcfc_adv_t rt [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
	int n_fail = 0, n_checks = 0, cyc = 0, k, q = PFCFC_QUANTUM_CYC;
	integer seed = 32'h5a44;
	pfcfc_port i_pfcfc_port (.mclk(mclk), .rst(rst), .mode(mode), .cfg_adv(cfg_adv), .pfc_tx_en(pfc_tx_en),
		.pfc_rx_en(pfc_rx_en), .pause_time(pause_time), .hi_mark(hi_mark), .lo_mark(lo_mark), .rxq_depth(rxq_depth),
		.rx_frame(rx_frame), .rx_frame_pri(rx_frame_pri), .link_up(link_up), .an_done(an_done),
		.partner_adv(partner_adv), .rx_pause(rx_pause), .tx_busy(tx_busy), .tx_pause_ack(tx_pause_ack),
		.adv_out(adv_out), .eff_tx_en(eff_tx_en), .eff_rx_en(eff_rx_en), .tx_pause_req(tx_pause_req),
		.tx_pause(tx_pause), .txq_halt(txq_halt));
	pfcfc_mac_model i_pfcfc_mac_model (.mclk(mclk), .rst(rst), .busy_en(busy_en), .slow(slow),
		.tx_pause_req(tx_pause_req), .tx_busy(tx_busy), .tx_pause_ack(tx_pause_ack));
	// ****************************************
	// helpers
	// ****************************************
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			wrap_up;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch %0t seen %h wanted %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task wreq(input int n);
		got = 1'b0;
		repeat (n)
		begin
			@(negedge mclk);
			if (tx_pause_req === 1'b1 && !got)
			begin
				got = 1'b1;
				tp = tx_pause;
			end
		end
	endtask
	task rxp(input logic pfc, input logic [7:0] mk, input logic [7:0][15:0] qv);
		rx_pause = {1'b1, pfc, mk, qv};
		tick(1);
		rx_pause.valid = 1'b0;
	endtask
	task frame;
		rx_frame_pri = 3'($random(seed));
		rx_frame = 1'b1;
		tick(1);
		rx_frame = 1'b0;
	endtask
	task halt_len(input logic [15:0] n, input int lo, input int hi);
		rxp(1'b0, 8'hff, {8{n}});
		k = 0;
		repeat (hi + 4)
		begin
			@(negedge mclk);
			k += (txq_halt === PFCFC_ALL);
		end
		chk(k >= lo && k <= hi + 2, 1'b1);
	endtask
	function logic [1:0] neg(pfcfc_adv_t l, pfcfc_adv_t r);
		return (!r.rx && !r.tx) ? 2'h0 : (l.rx && r.rx) ? 2'h3 : l.rx ? 2'h1 : 2'h2;
	endfunction
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		pause_time = 16'($random(seed));
		tick(4);
		rst = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			cfg_adv = (i < 4) ? lt[i] : 2'($random(seed)) | 2'(i % 2 == 0 ? 2 : 0);
			partner_adv = (i < 4) ? rt[i] : (i % 2) ? 2'h0 : 2'($random(seed)) | 2'h2;
			link_up = 1'b1;
			an_done = 1'b1;
			tick(1);
			an_done = 1'b0;
			tick(2);
			chk({eff_tx_en, eff_rx_en}, neg(cfg_adv, partner_adv));
			chk(adv_out, cfg_adv);
			cfg_adv = ~cfg_adv;
			tick(1);
			chk({eff_rx_en, eff_tx_en}, cfg_adv);
			link_up = 1'b0;
			tick(2);
			chk({eff_rx_en, eff_tx_en}, cfg_adv);
		end
		cfg_adv = 2'h3;
		$display("test 1 done");
		busy_en = 1'b1;
		slow = 1'b1;
		rxq_depth[0] = 16'h0065;
		wreq(30);
		chk({got, tp.is_pfc, tp.quanta}, {2'h2, pause_time});
		rxq_depth[0] = 16'h0033;
		frame;
		wreq(30);
		chk(got, 1'b1);
		rxq_depth[0] = 16'h0031;
		tick(2);
		frame;
		wreq(30);
		chk(got, 1'b0);
		cfg_adv = 2'h2;
		rxq_depth[0] = 16'h0065;
		wreq(30);
		chk(got, 1'b0);
		cfg_adv = 2'h3;
		rxq_depth[0] = 16'h0000;
		rxp(1'b0, 8'hff, {8{16'h0002}});
		tick(60);
		busy_en = 1'b0;
		tick(10);
		$display("test 2 done");
		halt_len(16'h0003, 2 * q, 3 * q);
		rxp(1'b0, 8'hff, {8{16'h0001}});
		tick(5);
		halt_len(16'h0004, 3 * q, 4 * q);
		rxp(1'b0, 8'hff, {8{16'h0005}});
		tick(4);
		rxp(1'b0, 8'hff, {8{16'h0000}});
		tick(3);
		chk(txq_halt, PFCFC_NONE);
		rxp(1'b1, 8'hff, {8{16'h0005}});
		tick(3);
		chk(txq_halt, PFCFC_NONE);
		$display("test 3 done");
		mode = PFCFC_MODE_PFC;
		pfc_tx_en = 8'h10;
		hi_mark[4] = 16'h00c8;
		rxq_depth[3] = 16'h00c9;
		rxq_depth[4] = 16'h0065;
		wreq(30);
		chk(got, 1'b0);
		rxq_depth[4] = 16'h00c9;
		wreq(30);
		chk({got, tp.is_pfc, tp.mask, tp.quanta}, {2'h3, 8'h10, pause_time});
		for (int i = 0; i < 6; i++)
		begin
			pfc_rx_en = (i == 0) ? 8'hff : 8'($random(seed));
			m = (i == 0) ? 8'hff : 8'($random(seed));
			rxp(1'b1, m, {4{16'h0006, 16'h0001}});
			tick(1);
			chk(txq_halt, m & pfc_rx_en);
			tick(3 * q);
			chk(txq_halt, m & pfc_rx_en & 8'haa);
			tick(4 * q);
		end
		rxp(1'b0, 8'hff, {8{16'h0004}});
		tick(3);
		chk(txq_halt, PFCFC_NONE);
		$display("test 4 done");
		wrap_up;
	end
endmodule // tb
`default_nettype wire
